// *** rtl/spt_timer.sv ***
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module spt_timer (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Event channel
  input wire logic i_event_in,
  output var spt_pkg::spt_evt_s o_evt,
  // Port pins
  output logic [5:0] o_pin_out,
  output logic [5:0] o_pin_oe,
  // Interrupt requests, one per flag bit
  output logic [6:0] o_int_req
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    if (a[1:0] != 2'h0) begin
      is_mapped = 1'b0;
    end else if (a <= spt_pkg::A_PINCFG) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction

  function automatic logic [9:0] presc_mask(input logic [2:0] sel);
    case (sel)
      3'h0: presc_mask = 10'h000;
      3'h1: presc_mask = 10'h001;
      3'h2: presc_mask = 10'h003;
      3'h3: presc_mask = 10'h007;
      3'h4: presc_mask = 10'h00F;
      3'h5: presc_mask = 10'h03F;
      3'h6: presc_mask = 10'h0FF;
      default: presc_mask = 10'h3FF;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic enable_ff;
  logic [2:0] presc_sel_ff;
  logic [2:0] waveform_mode_field_ff;
  logic alupd_ff;
  logic [2:0] cmpen_ff;
  logic [2:0] hcmpen_ff;
  logic split_ff;
  logic lock_ff;
  logic dir_ff;
  logic count_on_event_bit_ff;
  logic [1:0] event_action_field_ff;
  logic [6:0] interrupt_control_register_ff;
  logic [6:0] flags_ff;
  logic [15:0] cnt_ff;
  logic [15:0] per_ff;
  logic [2:0][15:0] cmp_ff;
  logic [15:0] perbuf_ff;
  logic [2:0][15:0] cmpbuf_ff;
  logic [3:0] bv_ff;
  logic [5:0] pin_val_ff;
  logic [5:0] pin_dir_ff;
  logic [5:0] pin_inv_ff;
  logic [5:0] wave_ff;
  logic [9:0] presc_ff;
  logic ev_s1_ff;
  logic ev_s2_ff;
  logic ev_d_ff;
  spt_pkg::spt_evt_s evt_ff;
  logic [5:0] pin_out_ff;
  logic [5:0] pin_oe_ff;
  logic [6:0] int_req_ff;

  // ----------------------------------------
  // Bus strobes and commands
  // ----------------------------------------
  logic wr;
  logic [1:0] cmd;
  logic cmd_upd;
  logic cmd_restart;
  logic srst;

  assign wr = i_psel && i_penable && pready_ff && i_pwrite && is_mapped(i_paddr);
  assign cmd = (wr && i_paddr == spt_pkg::A_CONTROL_E_SET_REGISTER) ?
               i_pwdata[spt_pkg::F_CMD +: 2] : 2'h0;
  assign cmd_upd = (cmd == spt_pkg::CMD_UPDATE);
  assign cmd_restart = (cmd == spt_pkg::CMD_RESTART);
  assign srst = (cmd == spt_pkg::CMD_RESET) && !enable_ff;

  // ----------------------------------------
  // APB answer: one access cycle, registered data
  // ----------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_paddr == spt_pkg::A_CTRLA) begin
      rd_mux = {28'h0, presc_sel_ff, enable_ff};
    end else if (i_paddr == spt_pkg::A_CTRLB) begin
      rd_mux = {21'h0, hcmpen_ff, 1'b0, cmpen_ff, alupd_ff, waveform_mode_field_ff};
    end else if (i_paddr == spt_pkg::A_CTRLD) begin
      rd_mux = {31'h0, split_ff};
    end else if (i_paddr == spt_pkg::A_CTRLECLR || i_paddr == spt_pkg::A_CONTROL_E_SET_REGISTER) begin
      rd_mux = {30'h0, lock_ff, dir_ff};
    end else if (i_paddr == spt_pkg::A_EVCTRL) begin
      rd_mux = {29'h0, event_action_field_ff, count_on_event_bit_ff};
    end else if (i_paddr == spt_pkg::A_INTERRUPT_CONTROL_REGISTER) begin
      rd_mux = {25'h0, interrupt_control_register_ff};
    end else if (i_paddr == spt_pkg::A_INTERRUPT_FLAGS_REGISTER) begin
      rd_mux = {25'h0, flags_ff};
    end else if (i_paddr == spt_pkg::A_CNT) begin
      rd_mux = {16'h0, cnt_ff};
    end else if (i_paddr == spt_pkg::A_PER) begin
      rd_mux = {16'h0, per_ff};
    end else if (i_paddr >= spt_pkg::A_CMP0 && i_paddr < spt_pkg::A_PERBUF) begin
      rd_mux = {16'h0, cmp_ff[2'(i_paddr[3:2] - 2'h2)]};
    end else if (i_paddr == spt_pkg::A_PERBUF) begin
      rd_mux = {16'h0, perbuf_ff};
    end else if (i_paddr >= spt_pkg::A_CMPBUF0 && i_paddr < spt_pkg::A_BVALID) begin
      rd_mux = {16'h0, cmpbuf_ff[2'(i_paddr[3:2] - 2'h2)]};
    end else if (i_paddr == spt_pkg::A_BVALID) begin
      rd_mux = {28'h0, bv_ff};
    end else if (i_paddr == spt_pkg::A_PINCFG) begin
      rd_mux = {10'h0, pin_inv_ff, 2'h0, pin_dir_ff, 2'h0, pin_val_ff};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= i_psel && !i_penable;
      pslverr_ff <= i_psel && !i_penable && !is_mapped(i_paddr);
      // Refused reads return zero, also for unaligned hits inside a range
      if (i_psel && !i_penable && !i_pwrite) begin
        prdata_ff <= is_mapped(i_paddr) ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      enable_ff <= 1'b0;
      presc_sel_ff <= 3'h0;
      waveform_mode_field_ff <= 3'h0;
      alupd_ff <= 1'b0;
      cmpen_ff <= 3'h0;
      hcmpen_ff <= 3'h0;
      split_ff <= 1'b0;
      count_on_event_bit_ff <= 1'b0;
      event_action_field_ff <= 2'h0;
      interrupt_control_register_ff <= 7'h00;
      lock_ff <= 1'b0;
    end else if (srst) begin
      enable_ff <= 1'b0;
      presc_sel_ff <= 3'h0;
      waveform_mode_field_ff <= 3'h0;
      alupd_ff <= 1'b0;
      cmpen_ff <= 3'h0;
      hcmpen_ff <= 3'h0;
      split_ff <= 1'b0;
      count_on_event_bit_ff <= 1'b0;
      event_action_field_ff <= 2'h0;
      interrupt_control_register_ff <= 7'h00;
      lock_ff <= 1'b0;
    end else if (wr) begin
      if (i_paddr == spt_pkg::A_CTRLA) begin
        enable_ff <= i_pwdata[spt_pkg::F_ENABLE];
        presc_sel_ff <= i_pwdata[spt_pkg::F_PRESC +: 3];
      end else if (i_paddr == spt_pkg::A_CTRLB) begin
        waveform_mode_field_ff <= i_pwdata[spt_pkg::F_WAVEFORM_MODE_FIELD +: 3];
        alupd_ff <= i_pwdata[spt_pkg::F_ALUPD];
        cmpen_ff <= i_pwdata[spt_pkg::F_CMPEN +: 3];
        hcmpen_ff <= i_pwdata[spt_pkg::F_HCMPEN +: 3];
      end else if (i_paddr == spt_pkg::A_CTRLD) begin
        split_ff <= i_pwdata[0];
      end else if (i_paddr == spt_pkg::A_CONTROL_E_SET_REGISTER) begin
        lock_ff <= lock_ff | i_pwdata[spt_pkg::F_LOCK_UPDATE_BIT];
      end else if (i_paddr == spt_pkg::A_CTRLECLR) begin
        lock_ff <= lock_ff & ~i_pwdata[spt_pkg::F_LOCK_UPDATE_BIT];
      end else if (i_paddr == spt_pkg::A_EVCTRL) begin
        count_on_event_bit_ff <= i_pwdata[spt_pkg::F_COUNT_ON_EVENT_BIT];
        event_action_field_ff <= i_pwdata[spt_pkg::F_EVENT_ACTION_FIELD +: 2];
      end else if (i_paddr == spt_pkg::A_INTERRUPT_CONTROL_REGISTER) begin
        interrupt_control_register_ff <= i_pwdata[6:0] & spt_pkg::FLAG_MASK;
      end
    end
  end

  // Pin settings belong to the port, so a timer reset leaves them alone
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_val_ff <= 6'h00;
      pin_dir_ff <= 6'h00;
      pin_inv_ff <= 6'h00;
    end else if (wr && i_paddr == spt_pkg::A_PINCFG) begin
      pin_val_ff <= i_pwdata[spt_pkg::F_PINOUT +: 6];
      pin_dir_ff <= i_pwdata[spt_pkg::F_PINDIR +: 6];
      pin_inv_ff <= i_pwdata[spt_pkg::F_PININV +: 6];
    end
  end

  // ----------------------------------------
  // Event input sync and timer tick
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ev_s1_ff <= 1'b0;
      ev_s2_ff <= 1'b0;
      ev_d_ff <= 1'b0;
      presc_ff <= 10'h000;
    end else begin
      ev_s1_ff <= i_event_in;
      ev_s2_ff <= ev_s1_ff;
      ev_d_ff <= ev_s2_ff;
      presc_ff <= enable_ff ? presc_ff + 10'h001 : 10'h000;
    end
  end

  logic presc_tick;
  logic ev_mode;
  logic tick;
  logic cnt_down;

  assign presc_tick = enable_ff && ((presc_ff & presc_mask(presc_sel_ff)) ==
                      presc_mask(presc_sel_ff));
  assign ev_mode = count_on_event_bit_ff && !split_ff;

  always_comb begin
    tick = presc_tick;
    cnt_down = dir_ff;
    if (ev_mode) begin
      case (event_action_field_ff)
        spt_pkg::EV_RISE: tick = enable_ff && ev_s2_ff && !ev_d_ff;
        spt_pkg::EV_BOTH: tick = enable_ff && (ev_s2_ff != ev_d_ff);
        spt_pkg::EV_HIGH: tick = presc_tick && ev_s2_ff;
        default: cnt_down = ev_s2_ff;
      endcase
    end
  end

  // ----------------------------------------
  // Counter next state
  // ----------------------------------------
  logic dual;
  logic [15:0] top;
  logic [15:0] nxt_cnt;
  logic nxt_dir;
  logic hit_top;
  logic hit_bot;
  logic ovf;
  logic low_underflow_source;
  logic high_underflow_source;
  logic upd_cond;
  logic [2:0] lmatch;
  logic [2:0] hmatch;

  assign dual = waveform_mode_field_ff[2] && (waveform_mode_field_ff != 3'h4);
  assign top = (waveform_mode_field_ff == spt_pkg::WG_FRQ) ? cmp_ff[0] : per_ff;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    hit_top = 1'b0;
    hit_bot = 1'b0;
    ovf = 1'b0;
    low_underflow_source = 1'b0;
    high_underflow_source = 1'b0;
    upd_cond = 1'b0;
    if (tick && split_ff) begin
      if (cnt_ff[7:0] == 8'h00) begin
        nxt_cnt[7:0] = per_ff[7:0];
        low_underflow_source = 1'b1;
      end else begin
        nxt_cnt[7:0] = cnt_ff[7:0] - 8'h01;
      end
      if (cnt_ff[15:8] == 8'h00) begin
        nxt_cnt[15:8] = per_ff[15:8];
        high_underflow_source = 1'b1;
      end else begin
        nxt_cnt[15:8] = cnt_ff[15:8] - 8'h01;
      end
    end else if (tick && dual) begin
      if (!dir_ff) begin
        if (cnt_ff >= per_ff) begin
          hit_top = 1'b1;
          nxt_dir = 1'b1;
          nxt_cnt = cnt_ff - 16'h0001;
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end else if (cnt_ff == 16'h0000) begin
        hit_bot = 1'b1;
        nxt_dir = 1'b0;
        nxt_cnt = 16'h0001;
      end else begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
      case (waveform_mode_field_ff)
        spt_pkg::WG_DSTOP: ovf = hit_top;
        spt_pkg::WG_DSBOTH: ovf = hit_top || hit_bot;
        default: ovf = hit_bot;
      endcase
      upd_cond = hit_bot;
    end else if (tick) begin
      if (!cnt_down) begin
        if (cnt_ff >= top) begin
          nxt_cnt = 16'h0000;
          ovf = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end else if (cnt_ff == 16'h0000) begin
        nxt_cnt = top;
        ovf = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
      upd_cond = ovf;
    end
  end

  generate
    for (genvar n = 0; n < 3; n++) begin : g_match
      assign lmatch[n] = tick && (split_ff ? cnt_ff[7:0] == cmp_ff[n][7:0] :
                                             cnt_ff == cmp_ff[n]);
      assign hmatch[n] = tick && split_ff && cnt_ff[15:8] == cmp_ff[n][15:8];
    end
  endgenerate

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_ff <= 16'h0000;
      dir_ff <= 1'b0;
    end else if (srst || cmd_restart) begin
      cnt_ff <= 16'h0000;
      dir_ff <= 1'b0;
    end else if (wr && i_paddr == spt_pkg::A_CNT) begin
      cnt_ff <= i_pwdata[15:0];
    end else begin
      cnt_ff <= nxt_cnt;
      if (wr && i_paddr == spt_pkg::A_CONTROL_E_SET_REGISTER && i_pwdata[spt_pkg::F_DIR]) begin
        dir_ff <= 1'b1;
      end else if (wr && i_paddr == spt_pkg::A_CTRLECLR && i_pwdata[spt_pkg::F_DIR]) begin
        dir_ff <= 1'b0;
      end else begin
        dir_ff <= nxt_dir;
      end
    end
  end

  // ----------------------------------------
  // Period, compare and buffers
  // ----------------------------------------
  logic upd_do;

  // Split mode leaves the buffers idle
  assign upd_do = !split_ff && (cmd_upd || (upd_cond && !lock_ff));

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      per_ff <= spt_pkg::PER_RST;
      perbuf_ff <= spt_pkg::PER_RST;
      cmp_ff <= '0;
      cmpbuf_ff <= '0;
      bv_ff <= 4'h0;
    end else if (srst) begin
      per_ff <= spt_pkg::PER_RST;
      perbuf_ff <= spt_pkg::PER_RST;
      cmp_ff <= '0;
      cmpbuf_ff <= '0;
      bv_ff <= 4'h0;
    end else begin
      if (upd_do && bv_ff[0]) begin
        per_ff <= perbuf_ff;
      end
      for (int n = 0; n < 3; n++) begin
        if (upd_do && bv_ff[n+1]) begin
          cmp_ff[n] <= cmpbuf_ff[n];
        end
      end
      // Buffer write wins over the update that would clear its flag
      bv_ff <= upd_do ? 4'h0 : bv_ff;
      if (wr && i_paddr == spt_pkg::A_PER) begin
        per_ff <= i_pwdata[15:0];
      end else if (wr && i_paddr >= spt_pkg::A_CMP0 && i_paddr < spt_pkg::A_PERBUF) begin
        cmp_ff[2'(i_paddr[3:2] - 2'h2)] <= i_pwdata[15:0];
      end else if (wr && i_paddr == spt_pkg::A_PERBUF) begin
        perbuf_ff <= i_pwdata[15:0];
        bv_ff <= (upd_do ? 4'h0 : bv_ff) | 4'h1;
      end else if (wr && i_paddr >= spt_pkg::A_CMPBUF0 && i_paddr < spt_pkg::A_BVALID) begin
        cmpbuf_ff[2'(i_paddr[3:2] - 2'h2)] <= i_pwdata[15:0];
        bv_ff <= (upd_do ? 4'h0 : bv_ff) | (4'h2 << (i_paddr[3:2] - 2'h2));
      end
    end
  end

  // ----------------------------------------
  // Waveform generation
  // ----------------------------------------
  logic [5:0] nxt_wave;

  always_comb begin
    nxt_wave = wave_ff;
    for (int n = 0; n < 3; n++) begin
      if (split_ff) begin
        if (low_underflow_source) begin
          nxt_wave[n] = 1'b1;
        end else if (lmatch[n]) begin
          nxt_wave[n] = 1'b0;
        end
        if (high_underflow_source) begin
          nxt_wave[n+3] = 1'b1;
        end else if (hmatch[n]) begin
          nxt_wave[n+3] = 1'b0;
        end
      end else if (dual) begin
        if (hit_bot) begin
          nxt_wave[n] = 1'b1;
        end else if (lmatch[n]) begin
          nxt_wave[n] = dir_ff;
        end
      end else if (waveform_mode_field_ff == spt_pkg::WG_FRQ) begin
        nxt_wave[n] = wave_ff[n] ^ lmatch[n];
      end else if (waveform_mode_field_ff == spt_pkg::WG_SINGLE) begin
        if (ovf) begin
          nxt_wave[n] = 1'b1;
        end else if (lmatch[n]) begin
          nxt_wave[n] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wave_ff <= 6'h00;
    end else if (srst || cmd_restart) begin
      wave_ff <= 6'h00;
    end else begin
      wave_ff <= nxt_wave;
    end
  end

  // Pin override, one cycle behind the waveform register
  logic [5:0] ovr;

  generate
    for (genvar p = 0; p < 6; p++) begin : g_pin
      if (p < 3) begin : g_lo
        assign ovr[p] = cmpen_ff[p] && waveform_mode_field_ff != spt_pkg::WG_NORMAL;
      end else begin : g_hi
        assign ovr[p] = split_ff && hcmpen_ff[p-3] && waveform_mode_field_ff != spt_pkg::WG_NORMAL;
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_out_ff <= 6'h00;
      pin_oe_ff <= 6'h00;
    end else begin
      pin_out_ff <= pin_inv_ff ^ ((ovr & wave_ff) | (~ovr & pin_val_ff));
      pin_oe_ff <= pin_dir_ff;
    end
  end

  // ----------------------------------------
  // Flags, requests and event strobes
  // ----------------------------------------
  logic [6:0] flag_set;

  // High-byte compares never reach a flag
  assign flag_set = {lmatch, 2'h0, split_ff && high_underflow_source, split_ff ? low_underflow_source : ovf};

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags_ff <= 7'h00;
      int_req_ff <= 7'h00;
      evt_ff <= '0;
    end else begin
      if (srst) begin
        flags_ff <= 7'h00;
      end else if (wr && i_paddr == spt_pkg::A_INTERRUPT_FLAGS_REGISTER) begin
        flags_ff <= (flags_ff & ~i_pwdata[6:0]) | flag_set;
      end else begin
        flags_ff <= flags_ff | flag_set;
      end
      int_req_ff <= flags_ff & interrupt_control_register_ff;
      evt_ff.ovf_unf <= split_ff ? low_underflow_source : ovf;
      evt_ff.high_underflow_source <= split_ff && high_underflow_source;
      evt_ff.cmp <= lmatch;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_evt = evt_ff;
  assign o_pin_out = pin_out_ff;
  assign o_pin_oe = pin_oe_ff;
  assign o_int_req = int_req_ff;

endmodule
`default_nettype wire

// *** rtl/spt_pkg.sv ***
// Overview of operation
// - Dual-slope: count bottom to period and back; set at bottom, clear up-match, set down-match.
// - Period value sets resolution, from 2 bits at 0x0003 up to 16 bits.
// - A dual-slope cycle lasts two times period value prescaled ticks.
// - Enabled channel in a waveform mode overrides pin value; pin driven only as output.
// - Pin inversion bit inverts the waveform seen on the pin.
// - Update, restart, reset commands written to control-E set register act immediately.
// - Update command copies buffers like a natural update, even while lock-update is set.
// - Restart command clears count value, direction and all compare outputs.
// - Reset command returns all timer registers to reset values, only while disabled.
// - Split mode makes two 8-bit timers with three compare channels each.
// - Split mode counts down with single-slope PWM only; no event actions.
// - In split mode low and high byte counters run independently.
// - In split mode buffers and buffer-valid flags are unused.
// - Split flags: low underflow, high underflow, low compare 0..2; none for high compares.
// - Normal flags: overflow on wrap, and compare channels 0, 1 and 2.
// - One-cycle event strobes on overflow, split underflow and compare matches 0..2.
// - Event actions: rising edges, both edges, high-level gating, or event-controlled direction.
// - Event counting only when count-on-event bit is set; action field picks the action.
// - Condition sets its flag; request active while flag and enable both set.
// - Update condition at bottom or top, depending on waveform mode.
// - Prescaler codes 0..7 divide by 1, 2, 4, 8, 16, 64, 256, 1024.
package spt_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] A_CTRLA = 8'h00;
  localparam logic [7:0] A_CTRLB = 8'h04;
  localparam logic [7:0] A_CTRLD = 8'h08;
  localparam logic [7:0] A_CTRLECLR = 8'h0C;
  localparam logic [7:0] A_CONTROL_E_SET_REGISTER = 8'h10;
  localparam logic [7:0] A_EVCTRL = 8'h14;
  localparam logic [7:0] A_INTERRUPT_CONTROL_REGISTER = 8'h18;
  localparam logic [7:0] A_INTERRUPT_FLAGS_REGISTER = 8'h1C;
  localparam logic [7:0] A_CNT = 8'h20;
  localparam logic [7:0] A_PER = 8'h24;
  localparam logic [7:0] A_CMP0 = 8'h28;
  localparam logic [7:0] A_PERBUF = 8'h34;
  localparam logic [7:0] A_CMPBUF0 = 8'h38;
  localparam logic [7:0] A_BVALID = 8'h44;
  localparam logic [7:0] A_PINCFG = 8'h48;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int F_ENABLE = 0;
  localparam int F_PRESC = 1;
  localparam int F_WAVEFORM_MODE_FIELD = 0;
  localparam int F_ALUPD = 3;
  localparam int F_CMPEN = 4;
  localparam int F_HCMPEN = 8;
  localparam int F_DIR = 0;
  localparam int F_LOCK_UPDATE_BIT = 1;
  localparam int F_CMD = 2;
  localparam int F_COUNT_ON_EVENT_BIT = 0;
  localparam int F_EVENT_ACTION_FIELD = 1;
  localparam int F_PINOUT = 0;
  localparam int F_PINDIR = 8;
  localparam int F_PININV = 16;
  localparam int FL_OVF = 0;
  localparam int FL_HIGH_UNDERFLOW_SOURCE = 1;
  localparam int FL_CMP = 4;

  // ----------------------------------------
  // Encodings and reset values
  // ----------------------------------------
  localparam logic [2:0] WG_NORMAL = 3'h0;
  localparam logic [2:0] WG_FRQ = 3'h1;
  localparam logic [2:0] WG_SINGLE = 3'h3;
  localparam logic [2:0] WG_DSTOP = 3'h5;
  localparam logic [2:0] WG_DSBOTH = 3'h6;
  localparam logic [2:0] WG_DSBOTTOM = 3'h7;
  localparam logic [1:0] CMD_UPDATE = 2'h1;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_RESET = 2'h3;
  localparam logic [1:0] EV_RISE = 2'h0;
  localparam logic [1:0] EV_BOTH = 2'h1;
  localparam logic [1:0] EV_HIGH = 2'h2;
  localparam logic [1:0] EV_DIR = 2'h3;
  localparam logic [15:0] PER_RST = 16'hFFFF;
  localparam logic [6:0] FLAG_MASK = 7'h73;

  // Event strobes towards the event channels
  typedef struct packed {
    logic ovf_unf;
    logic high_underflow_source;
    logic [2:0] cmp;
  } spt_evt_s;

endpackage

// *** verif/spt_timer_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module spt_timer_monitor (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Outputs
  input wire spt_pkg::spt_evt_s o_evt,
  input wire logic [5:0] o_pin_oe,
  input wire logic [6:0] o_int_req
);
  logic wr_acc;
  logic [4:0] evt_v;
  assign wr_acc = i_psel && i_penable && o_pready && i_pwrite;
  assign evt_v = o_evt;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  // ----------------
  // Bus answer
  // ----------------
  a_setup_gets_ready: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_error_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  a_error_reads_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
    else $error("refused read not zero");
  // ----------------
  // Requests, strobes, pins
  // ----------------
  a_irq_gap_zero:
    assert property (o_int_req[3:2] == 2'h0)
    else $error("unused request bit set");
  // Only a register write may drop a request
  a_irq_held_flag:
    assert property (|($past(o_int_req) & ~o_int_req) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("request dropped without write");
  a_strobe_one_cycle:
    assert property ((evt_v & $past(evt_v)) == 5'h0)
    else $error("event strobe longer than one cycle");
  a_drive_by_write:
    assert property ($changed(o_pin_oe) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("pin drive changed without write");
endmodule
bind spt_timer spt_timer_monitor u_mon (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_evt(o_evt), .o_pin_oe(o_pin_oe),
  .o_int_req(o_int_req));
`default_nettype wire

// *** verif/spt_pin_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
module spt_pin_partner (
  // Timer side
  input wire logic i_clk,
  input wire logic [5:0] i_pin_out,
  input wire logic [5:0] i_pin_oe,
  output logic o_event,
  // Pads
  output logic [5:0] o_pad
);
  // Undriven pad floats to its pull-up
  assign o_pad = (i_pin_oe & i_pin_out) | ~i_pin_oe;
  initial o_event = 1'b0;
  task automatic pulse(input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge i_clk);
      o_event <= 1'b1;
      repeat (gap) @(posedge i_clk);
      o_event <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** verif/tb_split_capable_pwm_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb_split_capable_pwm_timer;
  logic clk = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, ev;
  spt_pkg::spt_evt_s evt;
  logic [5:0] pin, oe, pad;
  logic [6:0] irq;
  int n_fail = 0, compares = 0, cyc = 0, seed = 32'h12ac;
  int hi, period_value, p, c, n;
  int dv[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  always #4 clk = ~clk;
  spt_timer dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_event_in(ev), .o_evt(evt),
    .o_pin_out(pin), .o_pin_oe(oe), .o_int_req(irq));
  spt_pin_partner u_far (.i_clk(clk), .i_pin_out(pin), .i_pin_oe(oe), .o_event(ev),
    .o_pad(pad));
  // ----------------
  // Bus and measuring tasks
  // ----------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Pad edges land after the clock edge, so the cycle count is already current
  task automatic meas(output int h, output int t);
    int t0;
    @(posedge pad[0]);
    t0 = cyc;
    @(negedge pad[0]);
    h = cyc - t0;
    @(posedge pad[0]);
    t = cyc - t0;
  endtask
  task automatic span(input int b, output int k);
    @(posedge clk iff evt[b]);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!evt[b]);
  endtask
  task automatic print_verdict;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Ceiling well above the longest prescaled PWM run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(spt_pkg::A_PER, 32'h0000FFFF);
    rdc(8'h4C, 32'h0);
    `CHK(err, 1'b1)
    wr(spt_pkg::A_CTRLB, 32'h17);
    wr(spt_pkg::A_INTERRUPT_CONTROL_REGISTER, 32'h10);
    for (int i = 0; i < 4; i++) begin
      wr(spt_pkg::A_CTRLA, 32'h0);
      wr(spt_pkg::A_CONTROL_E_SET_REGISTER, 32'h8);
      rdc(spt_pkg::A_CNT, 32'h0);
      rdc(spt_pkg::A_CTRLECLR, 32'h0);
      `CHK(pin[0], 1'(i > 0 && !i[0]))
      p = 3 + ($unsigned($random(seed)) % 8);
      c = 1 + ($unsigned($random(seed)) % (p - 1));
      wr(spt_pkg::A_PER, 32'(p));
      wr(spt_pkg::A_CMP0, 32'(c));
      wr(spt_pkg::A_PINCFG, {15'h0, i[0], 16'h0100});
      wr(spt_pkg::A_CTRLA, 32'({i[2:0], 1'b1}));
      meas(hi, period_value);
      `CHK(period_value, 2 * p * dv[i])
      `CHK(hi, 2 * dv[i] * (i[0] ? p - c : c))
    end
    wr(spt_pkg::A_CTRLA, 32'h0);
    `CHK(irq[4], 1'b1)
    wr(spt_pkg::A_INTERRUPT_FLAGS_REGISTER, 32'h73);
    // Request follows the flags one cycle late
    @(posedge clk);
    `CHK(irq, 7'h0)
    wr(spt_pkg::A_CONTROL_E_SET_REGISTER, 32'h2);
    wr(spt_pkg::A_PERBUF, 32'h9);
    wr(spt_pkg::A_CONTROL_E_SET_REGISTER, 32'h4);
    rdc(spt_pkg::A_PER, 32'h9);
    wr(spt_pkg::A_CTRLA, 32'h1);
    wr(spt_pkg::A_CONTROL_E_SET_REGISTER, 32'hC);
    rdc(spt_pkg::A_PER, 32'h9);
    wr(spt_pkg::A_CTRLA, 32'h0);
    wr(spt_pkg::A_CONTROL_E_SET_REGISTER, 32'hC);
    rdc(spt_pkg::A_PER, 32'h0000FFFF);
    rdc(spt_pkg::A_CTRLB, 32'h0);
    for (int a = 0; a < 3; a++) begin
      wr(spt_pkg::A_CONTROL_E_SET_REGISTER, 32'h8);
      wr(spt_pkg::A_EVCTRL, 32'(2 * a + 1));
      wr(spt_pkg::A_CTRLA, 32'h1);
      u_far.pulse(3, 4);
      repeat (6) @(posedge clk);
      wr(spt_pkg::A_CTRLA, 32'h0);
      rdc(spt_pkg::A_CNT, 32'(a == 2 ? 12 : 3 * (a + 1)));
    end
    wr(spt_pkg::A_CONTROL_E_SET_REGISTER, 32'hC);
    wr(spt_pkg::A_CTRLD, 32'h1);
    wr(spt_pkg::A_PER, 32'h0503);
    wr(spt_pkg::A_INTERRUPT_CONTROL_REGISTER, 32'h3);
    wr(spt_pkg::A_CTRLA, 32'h1);
    span(4, n);
    `CHK(n, 3 + 1)
    span(3, n);
    `CHK(n, 5 + 1)
    `CHK(irq[1:0], 2'h3)
    print_verdict();
  end
endmodule
`default_nettype wire
